// ### design/can_link_params.svh
`ifndef CAN_LINK_PARAMS_SVH
`define CAN_LINK_PARAMS_SVH

// ==========================================================================
// Clock and bit timing
// ==========================================================================
`define CLK_HZ             20000000
`define MIN_BIT_RATE_BPS   9600
`define BIT_RATE_BPS       500000
`define BIT_CYCLES         (`CLK_HZ / `BIT_RATE_BPS)
`define MAX_BIT_CYCLES     (`CLK_HZ / `MIN_BIT_RATE_BPS)
`define SAMPLE_POINT       (`BIT_CYCLES * 3 / 4)

// ==========================================================================
// Framing counts
// ==========================================================================
`define STUFF_RUN          5
`define ERROR_FLAG_BITS    6
`define MAX_DOM_RUN        11
`define FRAME_MAX_BITS     64
`define LEVEL_RECESSIVE    1'b1
`define LEVEL_DOMINANT     1'b0

`endif

// ### design/can_link_pkg.sv
package can_link_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_ERROR,
    ST_LOST
  } tx_state_e;
  typedef logic [5:0] bit_idx_t;
endpackage : can_link_pkg

// ### design/bit_timer.sv
`timescale 1ns/10ps
`include "can_link_params.svh"

// ==========================================================================
// Bit timer: one-cycle pulses at bit start and at the sample point.
// ==========================================================================
module bit_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  // Strobes
  output logic      bit_start,
  output logic      bit_sample
);
  localparam logic [5:0] LAST = 6'(`BIT_CYCLES - 1);
  localparam logic [5:0] SAMP = 6'(`SAMPLE_POINT);

  logic [5:0] cnt_r;

  assign bit_start  = run && (cnt_r == 6'h00);
  assign bit_sample = run && (cnt_r == SAMP);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 6'h00;
    end else if (!run || cnt_r == LAST) begin
      cnt_r <= 6'h00;
    end else begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
endmodule : bit_timer

// ### design/can_link_host.sv
// What this block does
// - High means recessive, low means dominant.
// - Recessive sent, dominant read: stop sending.
// - Stuff bit after five equal bits.
// - Error flag is six dominant bits.
// - Bit rate at least 9600 bps.
`timescale 1ns/10ps
`include "can_link_params.svh"

module can_link_host
  import can_link_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Frame request
  input  wire logic        send_req,
  input  wire logic [5:0]  send_len,
  input  wire logic [63:0] send_bits,
  input  wire logic        error_req,
  output logic             send_ready,
  // Frame result
  output logic             send_done,
  output logic             arb_lost,
  output logic             bit_error,
  // Receive stream
  output logic             rx_valid,
  output logic             rx_bit,
  // Transceiver pins
  output logic             txd,
  input  wire logic        rxd
);
  // ========================================================================
  // Pin synchroniser
  // ========================================================================
  logic rxd_meta_r;
  logic rxd_sync_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta_r <= `LEVEL_RECESSIVE;
      rxd_sync_r <= `LEVEL_RECESSIVE;
    end else begin
      rxd_meta_r <= rxd;
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // ========================================================================
  // Bit timing
  // ========================================================================
  tx_state_e state_r;
  tx_state_e state_nxt;
  logic      bit_start;
  logic      bit_sample;
  logic      active;

  assign active = (state_r == ST_SEND) || (state_r == ST_ERROR);

  // The bit rate is fixed well above the minimum so runs end early.
  bit_timer u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .run        (active),
    .bit_start  (bit_start),
    .bit_sample (bit_sample)
  );

  // ========================================================================
  // Frame state
  // ========================================================================
  logic [63:0] bits_r;
  bit_idx_t    left_r;
  bit_idx_t    idx_r;
  logic [2:0]  run_cnt_r;
  logic        last_lvl_r;
  logic        stuff_r;
  logic        txd_r;
  logic        done_r;
  logic        lost_r;
  logic        err_r;
  logic        rxv_r;
  logic        rxb_r;
  logic        fin_r;

  // A stuff bit is due after five equal bits; it carries the opposite level.
  logic stuff_due;
  logic data_lvl;
  logic drive_lvl;
  logic lost_now;
  logic err_now;
  logic last_bit;
  logic bit_go;

  assign stuff_due = (run_cnt_r == 3'(`STUFF_RUN));
  assign data_lvl  = bits_r[idx_r];
  assign drive_lvl = (state_r == ST_ERROR) ? `LEVEL_DOMINANT :
                     (stuff_due ? ~last_lvl_r : data_lvl);
  // Readback is the bus; recessive sent but dominant seen means we lost.
  assign lost_now  = bit_sample && state_r == ST_SEND &&
                     txd_r == `LEVEL_RECESSIVE &&
                     rxd_sync_r == `LEVEL_DOMINANT;
  assign err_now   = bit_sample && state_r == ST_SEND &&
                     txd_r == `LEVEL_DOMINANT &&
                     rxd_sync_r == `LEVEL_RECESSIVE;
  assign last_bit  = (left_r == 6'h00);
  // The frame ends at the next bit start, so the last bit stands a full bit.
  assign bit_go    = bit_start && !fin_r;
  assign send_ready = (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (error_req) begin
          state_nxt = ST_ERROR;
        end else if (send_req) begin
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (lost_now) begin
          state_nxt = ST_LOST;
        end else if (err_now) begin
          state_nxt = ST_ERROR;
        end else if (bit_start && fin_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ERROR: begin
        if (bit_start && fin_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_LOST: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_r     <= 64'h0000000000000000;
      left_r     <= 6'h00;
      idx_r      <= 6'h00;
      run_cnt_r  <= 3'h0;
      last_lvl_r <= `LEVEL_RECESSIVE;
      stuff_r    <= 1'b0;
      txd_r      <= `LEVEL_RECESSIVE;
      fin_r      <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      txd_r     <= `LEVEL_RECESSIVE;
      run_cnt_r <= 3'h0;
      stuff_r   <= 1'b0;
      idx_r     <= 6'h00;
      fin_r     <= 1'b0;
      if (error_req) begin
        left_r <= 6'(`ERROR_FLAG_BITS - 1);
      end else if (send_req) begin
        bits_r <= send_bits;
        left_r <= send_len;
      end
    end else if (!active) begin
      txd_r <= `LEVEL_RECESSIVE;
    end else if (bit_start && fin_r) begin
      txd_r <= `LEVEL_RECESSIVE;
    end else if (bit_go) begin
      txd_r   <= drive_lvl;
      stuff_r <= (state_r == ST_SEND) && stuff_due;
      // The error flag breaks stuffing on purpose, so it is not counted.
      if (state_r != ST_SEND) begin
        run_cnt_r <= 3'h0;
      end else if (stuff_due || drive_lvl != last_lvl_r) begin
        run_cnt_r <= 3'h1;
      end else begin
        run_cnt_r <= run_cnt_r + 3'h1;
      end
      last_lvl_r <= drive_lvl;
    end else if (bit_sample) begin
      fin_r <= last_bit && !stuff_r && !err_now;
      if (state_nxt == ST_ERROR && state_r == ST_SEND) begin
        left_r <= 6'(`ERROR_FLAG_BITS - 1);
      end else if (!stuff_r) begin
        left_r <= left_r - 6'h01;
        idx_r  <= idx_r + 6'h01;
      end
    end
  end

  // ========================================================================
  // Result and receive stream
  // ========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      lost_r <= 1'b0;
      err_r  <= 1'b0;
      rxv_r  <= 1'b0;
      rxb_r  <= `LEVEL_RECESSIVE;
    end else begin
      done_r <= (state_r == ST_SEND) && (state_nxt == ST_IDLE);
      lost_r <= lost_now;
      err_r  <= err_now;
      rxv_r  <= bit_sample;
      if (bit_sample) begin
        rxb_r <= rxd_sync_r;
      end
    end
  end

  assign txd       = txd_r;
  assign send_done = done_r;
  assign arb_lost  = lost_r;
  assign bit_error = err_r;
  assign rx_valid  = rxv_r;
  assign rx_bit    = rxb_r;

  // ========================================================================
  // Checks
  // ========================================================================
  logic [3:0] dom_run_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dom_run_r <= 4'h0;
    end else if (bit_go) begin
      dom_run_r <= (drive_lvl == `LEVEL_DOMINANT) ? dom_run_r + 4'h1 : 4'h0;
    end else if (!active) begin
      dom_run_r <= 4'h0;
    end
  end

  sequence s_lost_seen;
    lost_now;
  endsequence

  a_idle_recessive: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_r == ST_IDLE) |-> txd == `LEVEL_RECESSIVE)
    else $error("txd not recessive while idle");
  a_stuff_limit: assert property (
    @(posedge clk) disable iff (!rst_n)
    run_cnt_r <= 3'(`STUFF_RUN))
    else $error("run of equal bits too long");
  a_dom_run_cap: assert property (
    @(posedge clk) disable iff (!rst_n)
    dom_run_r <= 4'(`MAX_DOM_RUN))
    else $error("dominant run too long");
  a_lost_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_lost_seen |=> ##1 (txd == `LEVEL_RECESSIVE && send_ready))
    else $error("txd still driven after arbitration loss");
  a_error_dominant: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_r == ST_ERROR && bit_go) |=> txd == `LEVEL_DOMINANT)
    else $error("error flag bit not dominant");
  a_echo_sample: assert property (
    @(posedge clk) disable iff (!rst_n)
    bit_sample |=> rx_bit == $past(rxd_sync_r))
    else $error("receive bit not taken from bus");
endmodule : can_link_host

// ### verif/can_xcvr_model.sv
`timescale 1ns/10ps

// ==========================================================================
// Transceiver and bus seen at logic level; a second node may pull dominant.
// ==========================================================================
module can_xcvr_model #(
  parameter int DT_CYCLES = 600
) (
  // Logic side
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd,
  // Bus side conditions
  input  wire logic other_dom,
  input  wire logic hot,
  input  wire logic bus_off
);
  int unsigned dom_cnt_r   = 0;
  logic        timed_out_r = 1'b0;
  logic        tx_low;
  logic        drive_dom;
  logic        bus_dom;

  // A floating pin reads recessive through the pull-up.
  assign tx_low    = (txd === 1'b0);
  assign drive_dom = tx_low && !timed_out_r &&
                     !hot && !bus_off;
  assign bus_dom   = drive_dom || other_dom;
  assign rxd       = bus_off ? 1'b1 : !bus_dom;

  always @(posedge clk) begin
    if (!tx_low) begin
      dom_cnt_r   <= 0;
      timed_out_r <= 1'b0;
    end else if (dom_cnt_r >= DT_CYCLES) begin
      timed_out_r <= 1'b1;
    end else begin
      dom_cnt_r <= dom_cnt_r + 1;
    end
  end
endmodule : can_xcvr_model

// ### verif/isolated_can_bus_state_and_timeout_tb.sv
`timescale 1ns/10ps

// ==========================================================================
// Bench
// ==========================================================================
module isolated_can_bus_state_and_timeout_tb;
  logic        clk, rst_n, send_req, error_req, send_ready, send_done;
  logic        arb_lost, bit_error, rx_valid, rx_bit, txd, rxd;
  logic [5:0]  send_len;
  logic [63:0] send_bits;
  logic        other_dom, hot, bus_off, done_seen, arb_seen, berr_seen;
  logic        rx_q[$];
  logic [31:0] lfsr = 32'h655279C3;
  int          bad_count, samples_checked, low_cnt, cycles;

  can_link_host u_dut (.clk(clk), .rst_n(rst_n), .send_req(send_req),
    .send_len(send_len), .send_bits(send_bits), .error_req(error_req),
    .send_ready(send_ready), .send_done(send_done), .arb_lost(arb_lost),
    .bit_error(bit_error), .rx_valid(rx_valid), .rx_bit(rx_bit),
    .txd(txd), .rxd(rxd));
  can_xcvr_model u_xcvr (.clk(clk), .txd(txd), .rxd(rxd),
    .other_dom(other_dom), .hot(hot), .bus_off(bus_off));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (rx_valid === 1'b1) rx_q.push_back(rx_bit);
    if (send_done === 1'b1) done_seen = 1'b1;
    if (arb_lost === 1'b1) arb_seen = 1'b1;
    if (bit_error === 1'b1) berr_seen = 1'b1;
    if (txd === 1'b0) low_cnt++;
    if (cycles == 80000) begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic hit(input int sel);
    case (sel)
      0: return done_seen;
      1: return arb_seen;
      2: return berr_seen;
      default: return send_ready;
    endcase
  endfunction : hit

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_for(input int sel, input int limit);
    int n;
    n = 0;
    while (hit(sel) !== 1'b1 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (hit(sel) !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: wait for event %0d ran out", $time, sel);
    end
  endtask : wait_for

  task automatic start_req(input logic [5:0] len, input logic [63:0] bits,
                           input logic err);
    wait_for(3, 4000);
    send_len  = len;
    send_bits = bits;
    send_req  = !err;
    error_req = err;
    @(posedge clk);
    #1;
    send_req  = 1'b0;
    error_req = 1'b0;
  endtask : start_req

  // Destuffs the echoed stream so stuffing and payload are judged apart.
  task automatic send_frame(input logic [5:0] len, input logic [63:0] bits);
    int   run, k;
    logic prev;
    rx_q.delete();
    done_seen = 1'b0;
    start_req(len, bits, 1'b0);
    wait_for(0, 4000);
    check(done_seen, 1'b1);
    run = 0;
    k   = 0;
    prev = 1'bx;
    foreach (rx_q[i]) begin
      if (run == 5) begin
        check(rx_q[i], !prev);
        run = 1;
      end else begin
        run = (rx_q[i] === prev) ? run + 1 : 1;
        if (k <= len) check(rx_q[i], bits[k]);
        k++;
      end
      prev = rx_q[i];
    end
    check(k, len + 1);
  endtask : send_frame

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    {rst_n, send_req, error_req, other_dom, hot, bus_off} = '0;
    {done_seen, arb_seen, berr_seen} = '0;
    send_len  = '0;
    send_bits = '0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    check(txd, 1'b1);
    check(send_ready, 1'b1);
    send_frame(6'h3F, 64'h0);
    send_frame(6'h3F, 64'hFFFFFFFFFFFFFFFF);
    for (int n = 0; n < 6; n++) begin
      lfsr = lfsr_next(lfsr);
      send_bits[31:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      send_frame(lfsr[5:0], {lfsr, send_bits[31:0]});
    end
    other_dom = 1'b1;
    arb_seen  = 1'b0;
    start_req(6'h03, 64'hF, 1'b0);
    wait_for(1, 200);
    check(arb_seen, 1'b1);
    low_cnt = 0;
    repeat (100) @(posedge clk);
    #1 check(low_cnt, 0);
    other_dom = 1'b0;
    low_cnt = 0;
    start_req(6'h00, 64'h0, 1'b1);
    wait_for(3, 1000);
    repeat (5) @(posedge clk);
    #1 check(low_cnt, 240);
    hot = 1'b1;
    berr_seen = 1'b0;
    start_req(6'h07, 64'h0, 1'b0);
    wait_for(2, 200);
    check(berr_seen, 1'b1);
    wait_for(3, 2000);
    hot = 1'b0;
    test_done();
  end
endmodule : isolated_can_bus_state_and_timeout_tb
